//--- tx_bus_pkg.sv
/*
 * Shared constants and carrier types for the transmit telecom bus output.
 * Assumes one byte-wide STS-12 stream, twelve interleaved STS-1 channels.
 */
package tx_bus_pkg;

  // ************************************************************
  // register map
  // ************************************************************
  localparam logic [15:0] TX_BUS_CTRL_ADDR = 16'h0137; // direct address of tx_bus_control
  localparam logic [7:0]  TX_BUS_CTRL_RST  = 8'h00;    // bus disabled, data-only even parity
  localparam logic [7:0]  TX_BUS_CTRL_WMSK = 8'h07;    // writable bits
  localparam int          CTRL_EN_BIT      = 0;        // telecom bus enable
  localparam int          CTRL_COV_BIT     = 1;        // 1: parity also covers pl and marker
  localparam int          CTRL_ODD_BIT     = 2;        // 1: odd parity
  localparam int          CTRL_SEEN_BIT    = 7;        // read only: frame sync seen

  // ************************************************************
  // frame geometry
  // ************************************************************
  localparam logic [3:0]  FRAME_ROWS = 4'h9;           // rows per frame
  localparam logic [10:0] FRAME_COLS = 11'h438;        // 1080 byte columns per row
  localparam logic [10:0] TOH_COLS   = 11'h024;        // 36 transport overhead columns
  localparam logic [3:0]  STS1_COUNT = 4'hC;           // interleaved channels
  localparam logic [3:0]  C1_ROW     = 4'h0;           // row of first C1 byte
  localparam logic [10:0] C1_COL     = 11'h018;        // column of first C1 byte
  localparam logic [3:0]  J1_ROW     = 4'h0;           // fixed pointer puts J1 here
  localparam logic [10:0] J1_COL     = 11'h024;        // first payload column

  // one byte slot as driven on the bus
  typedef struct packed {
    logic [7:0] data;    // byte, msb on line seven
    logic       pl;      // payload indicator
    logic       marker;  // c1/j1 phase marker
    logic       alarm;   // path ais flag
    logic       parity;  // bus parity
  } bus_slot_s;

endpackage : tx_bus_pkg

//--- tx_bus_sync.sv
/*
 * Two-flop level synchroniser, any width.
 * Assumes each bit is a slow level or is widened by its sender.
 */
`timescale 1ns/1ns
module tx_bus_sync #(
  parameter int WIDTH = 1
) (
  // destination clock
  input  wire logic             clk_i,
  // level from the foreign domain
  input  wire logic [WIDTH-1:0] d_i,
  // synchronised level
  output logic      [WIDTH-1:0] q_o
);

  logic [WIDTH-1:0] meta_q;  // first stage, read only by the second
  logic [WIDTH-1:0] sync_q;  // second stage

  // plain chain; no reset so it also carries a reset level
  always_ff @(posedge clk_i) begin
    meta_q <= d_i;
    sync_q <= meta_q;
  end

  assign q_o = sync_q;

endmodule : tx_bus_sync

//--- sts12_tx_telecom_bus_out.sv
/*
 * Transmit STS-12 telecom bus output stage with its control register.
 * Assumes the synthesizer clock and frame sync share a source, and the
 * byte source and ais flags run on the synthesizer clock.
 */
`timescale 1ns/1ns

module sts12_tx_telecom_bus_out
  import tx_bus_pkg::*;
(
  // system clock and reset
  input  wire logic        clock_i,
  input  wire logic        srst_i,
  // register port
  input  wire logic [15:0] cpu_addr_i,
  input  wire logic        cpu_wr_i,
  input  wire logic        cpu_rd_i,
  input  wire logic [7:0]  cpu_wdata_i,
  output logic      [7:0]  cpu_rdata_o,
  output logic             cpu_ack_o,
  // synthesizer clock and forwarded bus clock
  input  wire logic        synth_clk_i,
  output logic             tx_bus_clock_o,
  // stream source on the synthesizer clock
  input  wire logic [7:0]  src_byte_i,
  input  wire logic [11:0] ais_p_i,
  output logic             slot_toh_o,
  output logic      [3:0]  slot_ch_o,
  // frame sync pin
  input  wire logic        frame_sync_8k_i,
  // telecom bus
  output logic      [7:0]  tx_bus_byte_o,
  output logic             payload_indicator_o,
  output logic             frame_path_phase_marker_o,
  output logic             path_ais_flag_o,
  output logic             tx_bus_parity_o
);

  // ************************************************************
  // register side (clock_i)
  // ************************************************************
  logic [7:0] ctrl_q;       // tx_bus_control storage
  logic [7:0] rdata_q;      // registered read data
  logic       ack_q;        // one-cycle access answer
  logic       seen_sys;     // frame seen, back in system domain
  logic       hit;          // address decode

  assign hit = (cpu_addr_i == TX_BUS_CTRL_ADDR);

  // control write; unmapped writes fall on the floor
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      ctrl_q <= TX_BUS_CTRL_RST;
    end else if (cpu_wr_i && hit) begin
      ctrl_q <= cpu_wdata_i & TX_BUS_CTRL_WMSK;
    end
  end

  // read data; unmapped and reserved bits read zero
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      rdata_q <= 8'h00;
    end else if (cpu_rd_i) begin
      rdata_q <= 8'h00;
      if (hit) begin
        rdata_q                <= ctrl_q;
        rdata_q[CTRL_SEEN_BIT] <= seen_sys;
      end
    end
  end

  // every strobe gets one answer pulse, write or read
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= cpu_wr_i | cpu_rd_i;
    end
  end

  assign cpu_rdata_o = rdata_q;
  assign cpu_ack_o   = ack_q;

  // ************************************************************
  // crossings
  // ************************************************************
  logic [2:0] ctrl_l;       // control bits on the bus clock
  logic [2:0] ctrl_p_q;     // previous synchronised control sample
  logic [2:0] ctrl_s_q;     // control word taken once two samples agree
  logic       rst_l;        // reset on the bus clock
  logic       sync_l;       // frame sync pin, synchronised
  logic       seen_q;       // frame sync seen, bus clock

  // each bit synchronised on its own; the word is filtered below
  tx_bus_sync #(.WIDTH(3)) u_ctrl_sync (
    .clk_i (synth_clk_i),
    .d_i   (ctrl_q[2:0]),
    .q_o   (ctrl_l)
  );

  // bits of one write may resolve an edge apart, so a word is taken
  // only after two equal samples; writes closer than two bus clocks
  // may merge, which is harmless for set-and-leave control
  always_ff @(posedge synth_clk_i) begin
    if (rst_l) begin
      ctrl_p_q <= TX_BUS_CTRL_RST[2:0];
      ctrl_s_q <= TX_BUS_CTRL_RST[2:0];
    end else begin
      ctrl_p_q <= ctrl_l;
      if (ctrl_l == ctrl_p_q) begin
        ctrl_s_q <= ctrl_l;
      end
    end
  end

  // reset level carried into the bus domain
  tx_bus_sync #(.WIDTH(1)) u_rst_sync (
    .clk_i (synth_clk_i),
    .d_i   (srst_i),
    .q_o   (rst_l)
  );

  // pin comes from outside, two flops before use
  tx_bus_sync #(.WIDTH(1)) u_fsync_sync (
    .clk_i (synth_clk_i),
    .d_i   (frame_sync_8k_i),
    .q_o   (sync_l)
  );

  // status level back to the register side
  tx_bus_sync #(.WIDTH(1)) u_seen_sync (
    .clk_i (clock_i),
    .d_i   (seen_q),
    .q_o   (seen_sys)
  );

  // ************************************************************
  // bus side (synth_clk_i)
  // ************************************************************
  logic        en_l;        // bus enabled
  logic        cov_l;       // wide parity coverage
  logic        odd_l;       // odd polarity
  logic        sync_d1_q;   // delayed sync for edge detect
  logic        sync_rise;   // frame start request
  logic [3:0]  row_q;       // next slot row
  logic [10:0] col_q;       // next slot column
  logic [3:0]  ch_q;        // next slot channel
  logic [3:0]  pos_row;     // slot being built
  logic [10:0] pos_col;
  logic [3:0]  pos_ch;
  logic        is_c1;       // slot holds first C1
  logic        is_j1;       // slot holds J1
  logic        ais_sel;     // ais of slot channel
  bus_slot_s   slot_d;      // next bus contents
  bus_slot_s   slot_q;      // bus contents

  assign en_l  = ctrl_s_q[CTRL_EN_BIT];
  assign cov_l = ctrl_s_q[CTRL_COV_BIT];
  assign odd_l = ctrl_s_q[CTRL_ODD_BIT];

  // bus clock is the synthesizer output itself, no own source
  assign tx_bus_clock_o = synth_clk_i;

  // edge detector reads only the second sync stage
  always_ff @(posedge synth_clk_i) begin
    if (rst_l) begin
      sync_d1_q <= 1'b0;
    end else begin
      sync_d1_q <= sync_l;
    end
  end

  assign sync_rise = sync_l & ~sync_d1_q;

  // a sync edge forces this slot to be byte one of a frame
  always_comb begin
    pos_row = row_q;
    pos_col = col_q;
    pos_ch  = ch_q;
    if (sync_rise) begin
      pos_row = 4'h0;
      pos_col = 11'h000;
      pos_ch  = 4'h0;
    end
  end

  // free-running frame counter; runs without sync too
  always_ff @(posedge synth_clk_i) begin
    if (rst_l) begin
      row_q <= 4'h0;
      col_q <= 11'h000;
      ch_q  <= 4'h0;
    end else begin
      ch_q  <= (pos_ch == STS1_COUNT - 4'h1) ? 4'h0 : pos_ch + 4'h1;
      col_q <= (pos_col == FRAME_COLS - 11'h001) ? 11'h000 : pos_col + 11'h001;
      if (pos_col == FRAME_COLS - 11'h001) begin
        row_q <= (pos_row == FRAME_ROWS - 4'h1) ? 4'h0 : pos_row + 4'h1;
      end else begin
        row_q <= pos_row;
      end
    end
  end

  // sticky while enabled; tells software frames are aligned
  always_ff @(posedge synth_clk_i) begin
    if (rst_l || !en_l) begin
      seen_q <= 1'b0;
    end else if (sync_rise) begin
      seen_q <= 1'b1;
    end
  end

  assign is_c1   = (pos_row == C1_ROW) && (pos_col == C1_COL);
  assign is_j1   = (pos_row == J1_ROW) && (pos_col == J1_COL);
  assign ais_sel = ais_p_i[pos_ch];

  // source sees where the byte it offers will land
  assign slot_toh_o = (pos_col < TOH_COLS);
  assign slot_ch_o  = pos_ch;

  // next slot; disabled bus sits at zero except parity, which carries the odd bit
  always_comb begin
    slot_d        = '0;
    slot_d.data   = en_l ? src_byte_i : 8'h00;
    slot_d.pl     = en_l && (pos_col >= TOH_COLS);
    slot_d.marker = en_l && (is_c1 || is_j1);
    slot_d.alarm  = en_l && ais_sel;
    // parity from the very values registered with it
    slot_d.parity = (^slot_d.data) ^ odd_l;
    if (cov_l) begin
      slot_d.parity = slot_d.parity ^ slot_d.pl ^ slot_d.marker;
    end
  end

  // all bus outputs launched on one rising edge
  always_ff @(posedge synth_clk_i) begin
    if (rst_l) begin
      slot_q <= '0;
    end else begin
      slot_q <= slot_d;
    end
  end

  assign tx_bus_byte_o             = slot_q.data;
  assign payload_indicator_o       = slot_q.pl;
  assign frame_path_phase_marker_o = slot_q.marker;
  assign path_ais_flag_o           = slot_q.alarm;
  assign tx_bus_parity_o           = slot_q.parity;

  // ************************************************************
  // assertions
  // ************************************************************
  property p_marker_single;
    @(posedge synth_clk_i) disable iff (rst_l)
    slot_q.marker |=> !slot_q.marker;
  endproperty
  a_marker_single: assert property (p_marker_single)
    else $error("phase marker longer than one cycle");
  property p_c1_marker;
    @(posedge synth_clk_i) disable iff (rst_l)
    (en_l && is_c1) |=> (slot_q.marker && !slot_q.pl);
  endproperty
  a_c1_marker: assert property (p_c1_marker)
    else $error("c1 slot without marker or with pl high");
  property p_j1_marker;
    @(posedge synth_clk_i) disable iff (rst_l)
    (en_l && is_j1) |=> (slot_q.marker && slot_q.pl);
  endproperty
  a_j1_marker: assert property (p_j1_marker)
    else $error("j1 slot without marker or with pl low");
  property p_marker_disabled;
    @(posedge synth_clk_i) disable iff (rst_l)
    !en_l |=> !slot_q.marker;
  endproperty
  a_marker_disabled: assert property (p_marker_disabled)
    else $error("marker active while bus disabled");
  property p_alarm_cause;
    @(posedge synth_clk_i) disable iff (rst_l)
    slot_q.alarm |-> ($past(ais_sel) && $past(en_l));
  endproperty
  a_alarm_cause: assert property (p_alarm_cause)
    else $error("alarm without ais on its channel");
  property p_parity_data;
    @(posedge synth_clk_i) disable iff (rst_l)
    !$past(cov_l) |-> (slot_q.parity == ((^slot_q.data) ^ $past(odd_l)));
  endproperty
  a_parity_data: assert property (p_parity_data)
    else $error("data parity wrong");
  property p_parity_full;
    @(posedge synth_clk_i) disable iff (rst_l)
    $past(cov_l) |->
      (slot_q.parity == ((^slot_q.data) ^ slot_q.pl ^ slot_q.marker ^ $past(odd_l)));
  endproperty
  a_parity_full: assert property (p_parity_full)
    else $error("wide parity wrong");
  property p_toh_pl;
    @(posedge synth_clk_i) disable iff (rst_l)
    (pos_col < TOH_COLS) |=> !slot_q.pl;
  endproperty
  a_toh_pl: assert property (p_toh_pl)
    else $error("pl high on overhead byte");
  property p_sync_start;
    @(posedge synth_clk_i) disable iff (rst_l)
    sync_rise |=> (row_q == 4'h0 && col_q == 11'h001 && !slot_q.pl);
  endproperty
  a_sync_start: assert property (p_sync_start)
    else $error("sync edge did not start a frame");
  c_c1_seen: cover property (@(posedge synth_clk_i) disable iff (rst_l)
    slot_q.marker && !slot_q.pl);
  c_j1_seen: cover property (@(posedge synth_clk_i) disable iff (rst_l)
    slot_q.marker && slot_q.pl);
  c_sync_seen: cover property (@(posedge synth_clk_i) disable iff (rst_l) sync_rise);
  c_alarm_seen: cover property (@(posedge synth_clk_i) disable iff (rst_l) slot_q.alarm);

endmodule : sts12_tx_telecom_bus_out

//--- tx_bus_far_end.sv
/*
 * Far-end framer model for the transmit telecom bus: sync source and capture.
 * Assumes the bench raises fire_i to ask for one frame sync pulse.
 */
`timescale 1ns/1ns
module tx_bus_far_end
  import tx_bus_pkg::*;
(
  // bus clock and request from the bench
  input  wire logic      bus_clock_i,
  input  wire logic      fire_i,
  // bus slot as seen at the pins
  input  wire bus_slot_s slot_i,
  // sync pulse towards the device
  output logic           frame_sync_8k_o
);
  // ****************************************
  // sync pulse and capture
  // ****************************************
  logic      fire_q;       // fire seen at last edge
  int        idx = 64;     // capture slot, 64 means idle
  bus_slot_s got_a [0:63]; // slots from the sync pulse on
  // one bus clock wide, launched on the rising edge so it stays in step
  always @(posedge bus_clock_i) begin
    fire_q          <= fire_i;
    frame_sync_8k_o <= fire_i & ~fire_q;
  end
  // capture mid-cycle, where the bus outputs are settled
  always @(negedge bus_clock_i) begin
    if (frame_sync_8k_o) idx = 0;
    if (idx < 64) begin
      got_a[idx] = slot_i;
      idx++;
    end
  end
endmodule : tx_bus_far_end

//--- sts12_tx_telecom_bus_out_test.sv
/*
 * Self-checking bench for the transmit telecom bus output stage.
 * Assumes the far-end model file and the design package are compiled first.
 */
`timescale 1ns/1ns
module sts12_tx_telecom_bus_out_test
  import tx_bus_pkg::*;
;
  // ****************************************
  // clocks, stimulus and observed signals
  // ****************************************
  logic        clock_i     = 1'b0;   // system clock
  logic        synth_clk_i = 1'b0;   // bus domain clock
  logic        srst_i      = 1'b1;   // held at start
  logic [15:0] cpu_addr_i  = 16'h0000;
  logic        cpu_wr_i    = 1'b0;
  logic        cpu_rd_i    = 1'b0;
  logic [7:0]  cpu_wdata_i = 8'h00;
  logic [7:0]  src_byte_i  = 8'h00;
  logic [11:0] ais_p_i     = 12'h000;
  logic        fire        = 1'b0;   // asks the far end for a sync
  logic        frame_sync_8k_i;
  logic [7:0]  cpu_rdata_o, tx_bus_byte_o;
  logic        cpu_ack_o, tx_bus_clock_o, payload_indicator_o;
  logic        slot_toh_o;           // slot being built is overhead
  logic [3:0]  slot_ch_o;            // channel of slot being built
  logic        frame_path_phase_marker_o, path_ais_flag_o, tx_bus_parity_o;
  bus_slot_s   slot;                 // bus pins gathered
  int          n_errors    = 0;
  int          check_count = 0;
  assign slot = {tx_bus_byte_o, payload_indicator_o, frame_path_phase_marker_o,
                 path_ais_flag_o, tx_bus_parity_o};
  initial forever #5 clock_i = ~clock_i;
  // bus clock offset so the two domains never share rising edges
  initial begin
    #2;
    forever #32 synth_clk_i = ~synth_clk_i;
  end
  sts12_tx_telecom_bus_out dut_u (.clock_i(clock_i), .srst_i(srst_i),
    .cpu_addr_i(cpu_addr_i), .cpu_wr_i(cpu_wr_i), .cpu_rd_i(cpu_rd_i),
    .cpu_wdata_i(cpu_wdata_i), .cpu_rdata_o(cpu_rdata_o), .cpu_ack_o(cpu_ack_o),
    .synth_clk_i(synth_clk_i), .tx_bus_clock_o(tx_bus_clock_o),
    .src_byte_i(src_byte_i), .ais_p_i(ais_p_i),
    .slot_toh_o(slot_toh_o), .slot_ch_o(slot_ch_o),
    .frame_sync_8k_i(frame_sync_8k_i), .tx_bus_byte_o(tx_bus_byte_o),
    .payload_indicator_o(payload_indicator_o),
    .frame_path_phase_marker_o(frame_path_phase_marker_o),
    .path_ais_flag_o(path_ais_flag_o), .tx_bus_parity_o(tx_bus_parity_o));
  tx_bus_far_end far_u (.bus_clock_i(tx_bus_clock_o), .fire_i(fire),
    .slot_i(slot), .frame_sync_8k_o(frame_sync_8k_i));
  // ****************************************
  // shared tasks
  // ****************************************
  task automatic end_sim;
    $display("checks %0d errors %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : end_sim
  task automatic chk(input logic [11:0] got, input logic [11:0] exp);
    check_count++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  // one strobe cycle, then a bounded wait for the answer pulse
  task automatic reg_acc(input logic wr, input logic [15:0] a, input logic [7:0] wd,
                         output logic [7:0] rd);
    int n = 0;
    @(posedge clock_i);
    cpu_wr_i    <= wr;
    cpu_rd_i    <= ~wr;
    cpu_addr_i  <= a;
    cpu_wdata_i <= wd;
    @(posedge clock_i);
    cpu_wr_i <= 1'b0;
    cpu_rd_i <= 1'b0;
    #1;
    while (cpu_ack_o !== 1'b1 && n < 8) begin
      @(posedge clock_i);
      #1;
      n++;
    end
    if (n == 8) begin
      n_errors++;
      end_sim();
    end
    rd = cpu_rdata_o;
  endtask : reg_acc
  // set control and source, then ask for one sync and let 66 slots pass
  task automatic frame_run(input logic [7:0] ctrl, input logic [7:0] src);
    logic [7:0] rd;
    reg_acc(1'b1, TX_BUS_CTRL_ADDR, ctrl, rd);
    @(posedge synth_clk_i);
    src_byte_i <= src;
    ais_p_i    <= 12'h020;
    repeat (5) @(posedge synth_clk_i);
    #1 chk(tx_bus_clock_o, synth_clk_i);
    @(posedge synth_clk_i) fire <= 1'b1;
    repeat (3) @(posedge synth_clk_i);
    fire <= 1'b0;
    #1 chk({slot_toh_o, slot_ch_o}, 12'h010);
    repeat (66) @(posedge synth_clk_i);
    #1 chk({slot_toh_o, slot_ch_o}, 12'h006);
  endtask : frame_run
  // ****************************************
  // scenarios
  // ****************************************
  // reset value, write mask, unmapped read
  task automatic reg_test;
    logic [7:0] rd;
    reg_acc(1'b0, TX_BUS_CTRL_ADDR, 8'h00, rd);
    chk(rd, 12'h000);
    reg_acc(1'b1, TX_BUS_CTRL_ADDR, 8'hFF, rd);
    reg_acc(1'b0, TX_BUS_CTRL_ADDR, 8'h00, rd);
    chk(rd, 12'h007);
    reg_acc(1'b0, 16'h0138, 8'h00, rd);
    chk(rd, 12'h000);
  endtask : reg_test
  // disabled bus: no marker, no alarm, only the odd bit on parity
  task automatic off_test;
    frame_run(8'h04, 8'hA5);
    for (int j = 0; j < 64; j++) chk(far_u.got_a[j], 12'h001);
  endtask : off_test
  // enabled: c1/j1 marking, overhead columns, alarm channel, parity modes
  task automatic on_test(input logic [7:0] ctrl, input logic [7:0] src);
    logic [7:0] rd;
    int         base = -9;
    bus_slot_s  e;
    frame_run(ctrl, src);
    for (int j = 63; j >= 0; j--)
      if (far_u.got_a[j].marker === 1'b1 && far_u.got_a[j].pl === 1'b0) base = j - 24;
    chk(base >= 1 && base <= 5, 12'h001);
    if (base >= 1 && base <= 5) begin
      for (int c = 0; c < 40; c++) begin
        e.data   = src;
        e.pl     = (c >= 36);
        e.marker = (c == 24 || c == 36);
        e.alarm  = (c % 12 == 5);
        e.parity = ^src ^ (ctrl[1] & (e.pl ^ e.marker)) ^ ctrl[2];
        chk(far_u.got_a[base + c].data, e.data);
        chk(far_u.got_a[base + c].pl, e.pl);
        chk(far_u.got_a[base + c].marker, e.marker);
        chk(far_u.got_a[base + c].alarm, e.alarm);
        chk(far_u.got_a[base + c].parity, e.parity);
      end
    end
    reg_acc(1'b0, TX_BUS_CTRL_ADDR, 8'h00, rd);
    chk(rd, {4'h0, 1'b1, 4'h0, ctrl[2:0]});
  endtask : on_test
  // ****************************************
  // main sequence
  // ****************************************
  // reset spans several bus clocks so the bus domain clears too
  initial begin
    repeat (30) @(posedge clock_i);
    srst_i <= 1'b0;
    reg_test();
    off_test();
    on_test(8'h01, 8'h80);
    on_test(8'h03, 8'h01);
    on_test(8'h05, 8'h81);
    on_test(8'h07, 8'h7E);
    end_sim();
  end
endmodule : sts12_tx_telecom_bus_out_test
